// ---- shared/sdcd_pkg.sv ----
// Package of constants and types for the SDRAM command and address decoder.
package sdcd_pkg;
	localparam int NUM_BANKS = 4;
	localparam int ADDR_W = 12;
	localparam int COL_W = 9;
	localparam int DATA_W = 16;
	localparam int LANES = 2;
	localparam int AP_BIT = 10;
	// Cycles a precharge takes before the bank is idle again.
	localparam logic [3:0] PRECHARGE_CYCLES = 4'h3;
	// Read data latency from the column command, in clock cycles.
	localparam logic [1:0] READ_LATENCY = 2'h2;
	localparam logic [11:0] MODE_RESET = 12'h000;
	typedef enum logic [2:0] {
		SDCD_NOP = 3'h0,
		SDCD_ACT = 3'h1,
		SDCD_PRE = 3'h2,
		SDCD_RD = 3'h3,
		SDCD_WR = 3'h4,
		SDCD_MRS = 3'h5,
		SDCD_OTHER = 3'h6
	} sdcd_cmd_t;
	typedef enum logic [1:0] {
		SDCD_IDLE = 2'h0,
		SDCD_ACTIVE = 2'h1,
		SDCD_PRECH = 2'h2
	} sdcd_bank_st_t;
endpackage

// ---- rtl/sdcd_bank.sv ----
// Per-bank state tracker: active state, open row and precharge timer.
module sdcd_bank
	import sdcd_pkg::*;
(
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic reset,
	// Decoded per-bank events.
	input wire logic act_hit,
	input wire logic pre_hit,
	input wire logic [ADDR_W-1:0] row_in,
	// Bank status.
	output logic bank_active,
	output logic [ADDR_W-1:0] open_row
);
	typedef struct packed {
		sdcd_bank_st_t st;
		logic [3:0] cnt;
		logic [ADDR_W-1:0] row;
	} sdcd_bank_s_t;
	sdcd_bank_s_t s_q, s_d;

	// Next state: activate opens a row, precharge closes it at once and the bank is idle again after a delay.
	always_comb begin
		s_d = s_q;
		unique case (s_q.st)
			SDCD_IDLE: begin
				if (act_hit) begin
					s_d.st = SDCD_ACTIVE;
					s_d.row = row_in;
				end
			end
			SDCD_ACTIVE: begin
				if (pre_hit) begin
					s_d.st = SDCD_PRECH;
					s_d.cnt = PRECHARGE_CYCLES;
				end
			end
			SDCD_PRECH: begin
				if (s_q.cnt == 4'h1) begin
					s_d.st = SDCD_IDLE;
				end
				s_d.cnt = s_q.cnt - 4'h1;
			end
			default: s_d.st = SDCD_IDLE;
		endcase
	end

	// State register.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			s_q <= '{st: SDCD_IDLE, cnt: 4'h0, row: '0};
		end else begin
			s_q <= s_d;
		end
	end

	assign bank_active = (s_q.st == SDCD_ACTIVE);
	assign open_row = s_q.row;
endmodule

// ---- rtl/sdcd_decoder.sv ----
// SDRAM command and address input decoder with a simple data path.
module sdcd_decoder
	import sdcd_pkg::*;
#(
	parameter int MEM_WORDS = 256
) (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic reset,
	// Command pins, active low strobes.
	input wire logic chip_select_n,
	input wire logic row_strobe_n,
	input wire logic col_strobe_n,
	input wire logic write_enable_n,
	// Bank and address.
	input wire logic [1:0] bank_select,
	input wire logic [ADDR_W-1:0] addr,
	// Byte masks.
	input wire logic low_byte_mask,
	input wire logic high_byte_mask,
	// Data bus as three signals.
	input wire logic [DATA_W-1:0] data_bus_in,
	output logic [DATA_W-1:0] data_bus_out,
	output logic [DATA_W-1:0] data_bus_oe,
	// Decode status.
	output logic [NUM_BANKS-1:0] bank_active,
	output logic [ADDR_W-1:0] mode_reg,
	output logic [2:0] last_cmd,
	output logic [COL_W-1:0] last_col,
	output logic last_auto_precharge,
	output logic [1:0] last_bank
);
	typedef struct packed {
		logic [ADDR_W-1:0] mode;
		sdcd_cmd_t cmd;
		logic [COL_W-1:0] col;
		logic ap;
		logic [1:0] bank;
		logic [READ_LATENCY-1:0] rd_pipe;
		logic [DATA_W-1:0] dout;
		logic [DATA_W-1:0] oe;
		logic [$clog2(MEM_WORDS)-1:0] ridx;
		logic [LANES-1:0] rmask;
	} sdcd_state_t;
	sdcd_state_t s_q, s_d;

	logic [DATA_W-1:0] mem [MEM_WORDS];
	logic [ADDR_W-1:0] open_row [NUM_BANKS];
	logic [NUM_BANKS-1:0] act_hit, pre_hit;
	sdcd_cmd_t cmd;
	logic [$clog2(MEM_WORDS)-1:0] widx;

	// Command decode from the strobes sampled together at the edge.
	always_comb begin
		cmd = SDCD_NOP;
		if (!chip_select_n) begin
			unique case ({row_strobe_n, col_strobe_n, write_enable_n})
				3'h3: cmd = SDCD_ACT;
				3'h2: cmd = SDCD_PRE;
				3'h5: cmd = SDCD_RD;
				3'h4: cmd = SDCD_WR;
				3'h0: cmd = SDCD_MRS;
				3'h7: cmd = SDCD_NOP;
				default: cmd = SDCD_OTHER;
			endcase
		end
	end

	// Per-bank hit lines: bank select decodes to one bank, line ten widens precharge.
	always_comb begin
		for (int b = 0; b < NUM_BANKS; b++) begin
			act_hit[b] = (cmd == SDCD_ACT) && (bank_select == b[1:0]);
			pre_hit[b] = (cmd == SDCD_PRE) && (addr[AP_BIT] || bank_select == b[1:0]);
		end
	end

	genvar g;
	generate
		for (g = 0; g < NUM_BANKS; g++) begin : g_bank
			sdcd_bank u_bank (
				.clk_sys(clk_sys),
				.reset(reset),
				.act_hit(act_hit[g]),
				.pre_hit(pre_hit[g]),
				.row_in(addr),
				.bank_active(bank_active[g]),
				.open_row(open_row[g])
			);
		end
	endgenerate

	// Word index from bank, low row bits and column, cut to the array width so only column bits 7:0 remain.
	assign widx = $clog2(MEM_WORDS)'({bank_select, open_row[bank_select][3:0], addr[COL_W-1:0]});

	// Next-state: capture command fields and run the read latency pipe.
	always_comb begin
		s_d = s_q;
		s_d.rd_pipe = {s_q.rd_pipe[READ_LATENCY-2:0], 1'b0};
		if (cmd != SDCD_NOP) begin
			s_d.cmd = cmd;
		end
		if (cmd == SDCD_MRS) begin
			s_d.mode = addr;
		end
		if ((cmd == SDCD_RD || cmd == SDCD_WR) && bank_active[bank_select]) begin
			s_d.col = addr[COL_W-1:0];
			s_d.ap = addr[AP_BIT];
			s_d.bank = bank_select;
			s_d.rd_pipe[0] = (cmd == SDCD_RD);
		end
		// The read index and masks are those sampled with the read command.
		if (cmd == SDCD_RD) begin
			s_d.ridx = widx;
			s_d.rmask = {high_byte_mask, low_byte_mask};
		end
		s_d.oe = '0;
		if (s_q.rd_pipe[READ_LATENCY-1]) begin
			s_d.dout = mem[s_q.ridx];
			s_d.oe = {{8{!s_q.rmask[1]}}, {8{!s_q.rmask[0]}}};
		end
	end

	// Registered state.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			s_q <= '{mode: MODE_RESET, cmd: SDCD_NOP, col: '0, ap: 1'b0, bank: 2'h0,
				rd_pipe: '0, dout: '0, oe: '0, ridx: '0, rmask: '0};
		end else begin
			s_q <= s_d;
		end
	end

	// Storage array; masked lanes are not written.
	always_ff @(posedge clk_sys) begin
		if (cmd == SDCD_WR && bank_active[bank_select]) begin
			if (!low_byte_mask) begin
				mem[widx][7:0] <= data_bus_in[7:0];
			end
			if (!high_byte_mask) begin
				mem[widx][15:8] <= data_bus_in[15:8];
			end
		end
	end

	assign data_bus_out = s_q.dout;
	assign data_bus_oe = s_q.oe;
	assign mode_reg = s_q.mode;
	assign last_cmd = s_q.cmd;
	assign last_col = s_q.col;
	assign last_auto_precharge = s_q.ap;
	assign last_bank = s_q.bank;

	property p_act_opens;
		@(posedge clk_sys) disable iff (reset)
		(cmd == SDCD_ACT && !bank_active[bank_select]) |=> bank_active[$past(bank_select)];
	endproperty
	a_act_opens: assert property (p_act_opens) else $error("Activate did not open bank.");

	property p_deselect;
		@(posedge clk_sys) disable iff (reset)
		chip_select_n |=> last_cmd == $past(last_cmd);
	endproperty
	a_deselect: assert property (p_deselect) else $error("Deselected command acted.");

	property p_pre_all;
		@(posedge clk_sys) disable iff (reset)
		(cmd == SDCD_PRE && addr[AP_BIT]) |=> ##3 bank_active == '0;
	endproperty
	a_pre_all: assert property (p_pre_all) else $error("Precharge all left a bank open.");

	property p_pre_one;
		@(posedge clk_sys) disable iff (reset)
		(cmd == SDCD_PRE && !addr[AP_BIT] && bank_active[bank_select]) |=>
			!bank_active[$past(bank_select)];
	endproperty
	a_pre_one: assert property (p_pre_one) else $error("Precharge did not close bank.");

	property p_mrs;
		@(posedge clk_sys) disable iff (reset)
		cmd == SDCD_MRS |=> mode_reg == $past(addr);
	endproperty
	a_mrs: assert property (p_mrs) else $error("Mode code not loaded.");

	property p_col;
		@(posedge clk_sys) disable iff (reset)
		((cmd == SDCD_RD || cmd == SDCD_WR) && bank_active[bank_select]) |=>
			last_col == $past(addr[COL_W-1:0]) && last_auto_precharge == $past(addr[AP_BIT]);
	endproperty
	a_col: assert property (p_col) else $error("Column fields not captured.");

	sequence s_read_issued;
		cmd == SDCD_RD && bank_active[bank_select] && !low_byte_mask;
	endsequence
	property p_read_drive;
		@(posedge clk_sys) disable iff (reset)
		s_read_issued |=> ##2 data_bus_oe[7:0] == 8'hFF;
	endproperty
	a_read_drive: assert property (p_read_drive) else $error("Read lane not driven.");

	property p_mask_off;
		@(posedge clk_sys) disable iff (reset)
		(cmd == SDCD_RD && bank_active[bank_select] && high_byte_mask) |=> ##2
			data_bus_oe[15:8] == 8'h00;
	endproperty
	a_mask_off: assert property (p_mask_off) else $error("Masked lane driven.");

	property p_idle_quiet;
		@(posedge clk_sys) disable iff (reset)
		(cmd != SDCD_RD) [*3] |=> data_bus_oe == '0;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("Bus driven without read.");

	// Row capture and the coding of commands that open nothing.
	property p_act_row;
		@(posedge clk_sys) disable iff (reset)
		(cmd == SDCD_ACT && !bank_active[bank_select]) |=>
			open_row[$past(bank_select)] == $past(addr);
	endproperty
	a_act_row: assert property (p_act_row) else $error("Activate row not latched.");

	property p_stop_other;
		@(posedge clk_sys) disable iff (reset)
		(!chip_select_n && row_strobe_n && col_strobe_n && !write_enable_n) |=>
			last_cmd == SDCD_OTHER;
	endproperty
	a_stop_other: assert property (p_stop_other) else $error("Strobe code not kept.");

	// A column command that reaches an open bank.
	sequence s_col_taken;
		(cmd == SDCD_RD || cmd == SDCD_WR) && bank_active[bank_select];
	endsequence
	property p_rw_bank;
		@(posedge clk_sys) disable iff (reset)
		s_col_taken |=> last_bank == $past(bank_select);
	endproperty
	a_rw_bank: assert property (p_rw_bank) else $error("Access bank not kept.");

	// A column command to a closed bank leaves the recorded column and bank alone.
	property p_col_refused;
		@(posedge clk_sys) disable iff (reset)
		((cmd == SDCD_RD || cmd == SDCD_WR) && !bank_active[bank_select]) |=>
			last_col == $past(last_col) && last_bank == $past(last_bank);
	endproperty
	a_col_refused: assert property (p_col_refused) else $error("Closed bank taken.");

	// Lane masking on the read drivers and on the storage writes.
	property p_low_mask_off;
		@(posedge clk_sys) disable iff (reset)
		(cmd == SDCD_RD && bank_active[bank_select] && low_byte_mask) |=> ##2
			data_bus_oe[7:0] == 8'h00;
	endproperty
	a_low_mask_off: assert property (p_low_mask_off) else $error("Low lane driven.");

	property p_wr_low;
		@(posedge clk_sys) disable iff (reset)
		(cmd == SDCD_WR && bank_active[bank_select] && low_byte_mask) |=>
			mem[$past(widx)][7:0] == $past(mem[widx][7:0]);
	endproperty
	a_wr_low: assert property (p_wr_low) else $error("Masked lane written.");

	property p_wr_high;
		@(posedge clk_sys) disable iff (reset)
		(cmd == SDCD_WR && bank_active[bank_select] && !high_byte_mask) |=>
			mem[$past(widx)][15:8] == $past(data_bus_in[15:8]);
	endproperty
	a_wr_high: assert property (p_wr_high) else $error("High lane not written.");

	// A lone read drives the bus for one cycle only.
	sequence s_read_alone;
		(cmd == SDCD_RD && bank_active[bank_select]) ##1 (cmd != SDCD_RD);
	endsequence
	property p_read_once;
		@(posedge clk_sys) disable iff (reset)
		s_read_alone |=> ##2 data_bus_oe == '0;
	endproperty
	a_read_once: assert property (p_read_once) else $error("Read data held too long.");

	// Mode code, precharge of all banks and deselect side effects.
	property p_mrs_keep;
		@(posedge clk_sys) disable iff (reset)
		(cmd != SDCD_MRS) |=> mode_reg == $past(mode_reg);
	endproperty
	a_mrs_keep: assert property (p_mrs_keep) else $error("Mode code changed.");

	property p_pre_all_now;
		@(posedge clk_sys) disable iff (reset)
		(cmd == SDCD_PRE && addr[AP_BIT]) |=> bank_active == '0;
	endproperty
	a_pre_all_now: assert property (p_pre_all_now) else $error("Bank left open.");

	property p_desel_open;
		@(posedge clk_sys) disable iff (reset)
		chip_select_n |=> (bank_active & ~$past(bank_active)) == '0;
	endproperty
	a_desel_open: assert property (p_desel_open) else $error("Bank opened.");
endmodule

// ---- bench/sdcd_ctrl_model.sv ----
// Behavioural memory controller that drives the command, address and data pins.
module sdcd_ctrl_model
	import sdcd_pkg::*;
(
	// Clock.
	input wire logic clk_sys,
	// Command strobes, bank and address.
	output logic cs_n,
	output logic ras_n,
	output logic cas_n,
	output logic we_n,
	output logic [1:0] ba,
	output logic [ADDR_W-1:0] addr,
	// Byte masks and write data.
	output logic lmask,
	output logic hmask,
	output logic [DATA_W-1:0] dout
);
	timeunit 1ns;
	timeprecision 100ps;

	// The bus starts as a selected no-operation with nothing masked.
	initial begin
		{cs_n, ras_n, cas_n, we_n} = 4'h7;
		ba = 2'h0;
		addr = 12'h000;
		{hmask, lmask} = 2'h0;
		dout = 16'h0000;
	end

	// Issues one command for a full cycle, then a no-operation with the data inverted.
	// Masks are held so that they still stand when read data comes back.
	task automatic cmd(input logic [3:0] pins, input logic [1:0] b, input logic [ADDR_W-1:0] a,
		input logic [1:0] m, input logic [DATA_W-1:0] d);
		@(negedge clk_sys);
		{cs_n, ras_n, cas_n, we_n} = pins;
		ba = b;
		addr = a;
		{hmask, lmask} = m;
		dout = d;
		@(negedge clk_sys);
		{cs_n, ras_n, cas_n, we_n} = 4'h7;
		dout = ~d;
	endtask
endmodule

// ---- bench/tb_sdram_command_address_decode.sv ----
// Self-checking testbench of the command and address decoder.
module tb_sdram_command_address_decode
	import sdcd_pkg::*;
();
	timeunit 1ns;
	timeprecision 100ps;

	logic clk_sys;
	logic reset;
	logic cs_n, ras_n, cas_n, we_n, lmask, hmask, last_ap;
	logic [1:0] ba, last_bank;
	logic [ADDR_W-1:0] addr, mode_reg;
	logic [DATA_W-1:0] din, data_bus_out, data_bus_oe;
	logic [NUM_BANKS-1:0] bank_active;
	logic [2:0] last_cmd;
	logic [COL_W-1:0] last_col;
	int n_mismatch = 0;
	int checked = 0;

	sdcd_ctrl_model u_sdcd_ctrl_model (.clk_sys(clk_sys), .cs_n(cs_n), .ras_n(ras_n),
		.cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .lmask(lmask), .hmask(hmask),
		.dout(din));

	sdcd_decoder u_sdcd_decoder (.clk_sys(clk_sys), .reset(reset), .chip_select_n(cs_n),
		.row_strobe_n(ras_n), .col_strobe_n(cas_n), .write_enable_n(we_n),
		.bank_select(ba), .addr(addr), .low_byte_mask(lmask), .high_byte_mask(hmask),
		.data_bus_in(din), .data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe),
		.bank_active(bank_active), .mode_reg(mode_reg), .last_cmd(last_cmd),
		.last_col(last_col), .last_auto_precharge(last_ap), .last_bank(last_bank));

	// Compares one value and counts the result.
	task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Reads column 1A5 of bank 2 and checks drive enables, data and the one-cycle pulse.
	task automatic rd(input logic [1:0] m, input logic [DATA_W-1:0] oe, input logic [DATA_W-1:0] d);
		int i;
		u_sdcd_ctrl_model.cmd(4'h5, 2'h2, 12'h1A5, m, 16'h0F0F);
		for (i = 0; i < 6 && data_bus_oe === 16'h0000; i++) @(negedge clk_sys);
		chk(data_bus_oe, oe);
		chk(data_bus_out & data_bus_oe, d);
		chk(last_cmd, SDCD_RD);
		@(negedge clk_sys);
		chk(data_bus_oe, 16'h0000);
	endtask

	// Mode register set with every bank idle.
	task automatic t_mode();
		u_sdcd_ctrl_model.cmd(4'h0, 2'h0, 12'hA5C, 2'h0, 16'h0000);
		chk(mode_reg, 12'hA5C);
		chk(last_cmd, SDCD_MRS);
	endtask

	// An activate with chip select high must change nothing; a burst stop counts as another code.
	task automatic t_desel();
		u_sdcd_ctrl_model.cmd(4'hB, 2'h2, 12'h123, 2'h0, 16'h0000);
		chk(bank_active, 4'h0);
		chk(last_cmd, SDCD_MRS);
		u_sdcd_ctrl_model.cmd(4'h6, 2'h0, 12'h000, 2'h0, 16'h0000);
		chk(last_cmd, SDCD_OTHER);
		chk(mode_reg, 12'hA5C);
	endtask

	// Activates banks 0 to 3 in turn; each bank select code lights only its own bank.
	task automatic t_act();
		for (int b = 0; b < 4; b++) begin
			u_sdcd_ctrl_model.cmd(4'h3, b[1:0], 12'hF05, 2'h0, 16'h0000);
			chk(bank_active, (16'h1 << (b + 1)) - 16'h1);
			chk(last_cmd, SDCD_ACT);
		end
	endtask

	// Full write, low-lane masked write, then masked and unmasked reads.
	task automatic t_rw();
		u_sdcd_ctrl_model.cmd(4'h4, 2'h2, 12'h5A5, 2'h0, 16'h1234);
		u_sdcd_ctrl_model.cmd(4'h4, 2'h2, 12'h5A5, 2'h1, 16'hABCD);
		chk(last_cmd, SDCD_WR);
		chk(last_col, 9'h1A5);
		chk(last_ap, 1'h1);
		chk(last_bank, 2'h2);
		rd(2'h2, 16'h00FF, 16'h0034);
		rd(2'h0, 16'hFFFF, 16'hAB34);
		rd(2'h1, 16'hFF00, 16'hAB00);
	endtask

	// Single-bank precharge, precharge of all banks, a refused write to a closed bank,
	// then an activate that is taken once the precharge has run its three cycles.
	task automatic t_pre();
		u_sdcd_ctrl_model.cmd(4'h2, 2'h1, 12'h000, 2'h0, 16'h0000);
		chk(bank_active, 4'hD);
		u_sdcd_ctrl_model.cmd(4'h2, 2'h3, 12'h400, 2'h0, 16'h0000);
		chk(bank_active, 4'h0);
		chk(last_cmd, SDCD_PRE);
		u_sdcd_ctrl_model.cmd(4'h4, 2'h2, 12'h000, 2'h0, 16'h5555);
		chk(last_col, 9'h1A5);
		u_sdcd_ctrl_model.cmd(4'h3, 2'h0, 12'h000, 2'h0, 16'h0000);
		chk(bank_active, 4'h1);
	endtask

	// A 50 ns clock.
	initial begin
		clk_sys = 1'h0;
		forever #25 clk_sys = ~clk_sys;
	end

	// Main sequence after three cycles of reset.
	initial begin
		reset = 1'h1;
		repeat (3) @(negedge clk_sys);
		reset = 1'h0;
		t_mode();
		t_desel();
		t_act();
		t_rw();
		t_pre();
		give_verdict();
	end

	// Cuts a hang short; the sequence needs well under a hundred cycles.
	initial begin
		#100000;
		n_mismatch++;
		give_verdict();
	end
endmodule
